// [bfp_checker.sv]
// Port-level assertions for the buck fault protection logic
`timescale 1ns/10ps
module bfp_checker
  import bfp_pkg::*;
#(
  parameter int SS_TIME_US_P = SS_TIME_US
) (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            supply_ok,
  input wire logic            comp_low,
  input wire logic            pwm_low_req,
  input wire logic [MV_W-1:0] output_sense,
  input wire logic            high_gate_drive,
  input wire logic            low_gate_drive,
  input wire logic            ocset_source_en,
  input wire logic            power_ok_out_oe,
  input wire logic [MV_W-1:0] ss_reference
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire ov_hi = output_sense > OV_TRIP_MV;
  wire lo_ok = (output_sense < OV_LG_OFF_MV) && !pwm_low_req;
  wire win   = (output_sense >= PG_LOW_MV) && (output_sense <= PG_HIGH_MV);
  wire dis   = comp_low || !supply_ok;
  sequence s_ov_hold;
    ov_hi [*8];
  endsequence
  sequence s_ov_running;
    high_gate_drive ##1 s_ov_hold;
  endsequence
  a_ocset_pg_low: assert property (ocset_source_en |-> power_ok_out_oe)
    else $error("Power-good released while sampling threshold");
  a_ramp_pg_low: assert property ($changed(ss_reference) |-> power_ok_out_oe)
    else $error("Power-good released while ramp moves");
  // Sync pipeline lag lets the window hold a few cycles back
  a_pg_window: assert property (!power_ok_out_oe |->
    $past(win, 2) || $past(win, 3) || $past(win, 4))
    else $error("Power-good released outside window");
  a_ov_hg_off: assert property (high_gate_drive && ov_hi |-> ##[1:6] !high_gate_drive)
    else $error("High gate kept on in overvoltage");
  a_ov_lg_on: assert property (s_ov_running |-> low_gate_drive)
    else $error("Low gate not on in overvoltage");
  a_ov_lg_off: assert property (lo_ok [*6] |-> !low_gate_drive)
    else $error("Low gate on below release level");
  a_ramp_step: assert property ($changed(ss_reference) |->
    ss_reference == $past(ss_reference) + 11'h001 || ss_reference == 11'h000
    || $past(ocset_source_en) || $past(ocset_source_en, 2))
    else $error("Ramp jumped");
  a_ramp_max: assert property (ss_reference <= VREF_MV)
    else $error("Ramp above reference");
  a_dis_clear: assert property (dis [*6] |-> ss_reference == 11'h000 && !ocset_source_en)
    else $error("Ramp not cleared on disable");
  a_ocset_supply: assert property ($rose(ocset_source_en) |->
    $past(supply_ok, 2) && $past(supply_ok, 3))
    else $error("Threshold source on without supply");
endmodule

bind bfp_top bfp_checker #(.SS_TIME_US_P(SS_TIME_US_P)) i_chk (.clk, .reset, .supply_ok,
  .comp_low, .pwm_low_req, .output_sense, .high_gate_drive, .low_gate_drive,
  .ocset_source_en, .power_ok_out_oe, .ss_reference);

// [bfp_pkg.sv]
// Shared constants, bus carriers and state codes for the buck fault protection logic
package bfp_pkg;

  localparam int          CLK_HZ           = 50_000_000;
  localparam int          MV_W             = 11;
  localparam int          ADDR_W           = 8;

  // Voltage codes are in millivolts
  localparam logic [10:0] OC_THRESH_MAX_MV = 11'h280;
  localparam logic [10:0] VREF_MV          = 11'h320;
  localparam logic [10:0] PG_LOW_MV        = 11'h2D0;
  localparam logic [10:0] PG_HIGH_MV       = 11'h370;
  localparam logic [10:0] OV_TRIP_MV       = 11'h3E8;
  localparam logic [10:0] OV_LG_OFF_MV     = 11'h190;
  localparam logic [10:0] UV_TRIP_MV       = 11'h258;

  localparam logic [2:0]  OC_TRIP_COUNT    = 3'h4;
  localparam int          SS_TIME_US       = 4000;
  localparam int          OCSET_SETTLE_US  = 20;
  localparam int          OCSET_SETTLE_CYC = (CLK_HZ / 1_000_000) * OCSET_SETTLE_US;

  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS       = 8'h04;
  localparam logic [7:0]  OC_THRESH_OFS    = 8'h08;
  localparam logic [7:0]  SS_REF_OFS       = 8'h0C;
  localparam logic [7:0]  OUT_SENSE_OFS    = 8'h10;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  localparam int          CTRL_DISABLE_BIT = 0;
  localparam int          ST_OC_BIT        = 0;
  localparam int          ST_OV_BIT        = 1;
  localparam int          ST_UV_BIT        = 2;
  localparam int          ST_PG_BIT        = 3;
  localparam int          ST_SS_DONE_BIT   = 4;
  localparam int          ST_STATE_LSB     = 8;

  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [4:0] {
    BFP_IDLE  = 5'b00001,
    BFP_OCSET = 5'b00010,
    BFP_SOFT  = 5'b00100,
    BFP_RUN   = 5'b01000,
    BFP_SPARE = 5'b10000
  } bfp_state_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } bfp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bfp_axi_rsp_t;

endpackage

// [bfp_plant.sv]
// Switching-stage model: low-side sample strobe, switch drop and threshold pin
`timescale 1ns/10ps
module bfp_plant
  import bfp_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            ocset_source_en,
  input  wire logic [MV_W-1:0] rset_mv,
  input  wire logic [MV_W-1:0] drop_mv,
  output logic                 low_off_strobe,
  output logic      [MV_W-1:0] switch_node_sense,
  output logic      [MV_W-1:0] overcurrent_set_resistor
);
  logic [3:0] phase;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end
  // Period of 16 clocks keeps sample spacing far above the sync lag
  assign low_off_strobe = (phase == 4'hF);
  assign switch_node_sense = drop_mv;
  // Without the source current the pin carries no valid level
  assign overcurrent_set_resistor = ocset_source_en ? rset_mv : ~rset_mv;
endmodule

// [bfp_ramp.sv]
// Soft-start reference ramp with precharge start value
`timescale 1ns/10ps
module bfp_ramp
  import bfp_pkg::*;
#(
  parameter int STEP_CYC = 250
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            clear,
  input  wire logic            start,
  input  wire logic [MV_W-1:0] init_mv,
  output logic      [MV_W-1:0] ref_mv,
  output logic                 done
);
  logic [17:0] step_cnt;
  logic        running;
  wire         step_hit = (step_cnt == 18'(STEP_CYC - 1));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_mv   <= '0;
      running  <= 1'b0;
      done     <= 1'b0;
      step_cnt <= '0;
    end else if (clear) begin
      ref_mv   <= '0;
      running  <= 1'b0;
      done     <= 1'b0;
      step_cnt <= '0;
    end else if (start) begin
      ref_mv   <= init_mv;
      running  <= 1'b1;
      done     <= 1'b0;
      step_cnt <= '0;
    end else if (running) begin
      step_cnt <= step_hit ? 18'h0_0000 : step_cnt + 18'h0_0001;
      if (ref_mv >= VREF_MV) begin
        running <= 1'b0;
        done    <= 1'b1;
      end else if (step_hit) begin
        ref_mv <= ref_mv + 11'h001;
      end
    end
  end
endmodule

// [bfp_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module bfp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // Multi-bit codes are assumed to change slowly against the clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// [bfp_top.sv]
// Buck controller protection, soft start and power-good logic with AXI4-Lite status
//
// Operation
// - Sample switch drop at low-side conduction end
// - Count exceeding samples, clear on non-exceeding
// - Latch overcurrent after four consecutive exceedances
// - Overcurrent fault forces both gates off
// - Overcurrent fault cleared only by power cycle
// - Source current, sample threshold after lockout release
// - Threshold saturates at 640 mV maximum
// - Ramp reference zero to 800 mV, 4 ms
// - Restart ramp on lockout or compensation disable
// - Start ramp from existing output level
// - Pull power-good low in soft start, faults
// - Release power-good only within ten percent window
// - Overvoltage latches fault, high gate held low
// - Overvoltage low gate hysteresis 1 V/400 mV
// - Overvoltage fault persists until power cycle
// - Undervoltage armed after soft start, then latches
// - Undervoltage fault forces both gates low
// - Undervoltage fault cleared only by power cycle
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module bfp_top
  import bfp_pkg::*;
#(
  parameter int SS_TIME_US_P = SS_TIME_US
) (
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            supply_ok,
  input  wire logic            comp_low,
  input  wire logic            low_off_strobe,
  input  wire logic            pwm_high_req,
  input  wire logic            pwm_low_req,
  input  wire logic [MV_W-1:0] switch_node_sense,
  input  wire logic [MV_W-1:0] output_sense,
  input  wire logic [MV_W-1:0] overcurrent_set_resistor,
  input  wire bfp_pkg::bfp_axi_req_t s_axi_req,
  output bfp_pkg::bfp_axi_rsp_t      s_axi_rsp,
  output logic                 high_gate_drive,
  output logic                 low_gate_drive,
  output logic                 ocset_source_en,
  output logic                 power_ok_out_o,
  output logic                 power_ok_out_oe,
  output logic      [MV_W-1:0] ss_reference
);
  import bfp_pkg::*;

  localparam int SS_STEP_CYC = ((CLK_HZ / 1_000_000) * SS_TIME_US_P) / int'(VREF_MV);

  // Pin synchronisation
  logic [MV_W-1:0] sw_drop;
  logic [MV_W-1:0] out_mv;
  logic [MV_W-1:0] ocset_mv;
  logic            supply_s;
  logic            comp_low_s;

  bfp_sync #(.W(MV_W)) u_sync_sw (
    .clk      (clk),
    .reset    (reset),
    .async_in (switch_node_sense),
    .sync_out (sw_drop)
  );
  bfp_sync #(.W(MV_W)) u_sync_out (
    .clk      (clk),
    .reset    (reset),
    .async_in (output_sense),
    .sync_out (out_mv)
  );
  bfp_sync #(.W(MV_W)) u_sync_ocs (
    .clk      (clk),
    .reset    (reset),
    .async_in (overcurrent_set_resistor),
    .sync_out (ocset_mv)
  );
  bfp_sync #(.W(2)) u_sync_lvl (
    .clk      (clk),
    .reset    (reset),
    .async_in ({supply_ok, comp_low}),
    .sync_out ({supply_s, comp_low_s})
  );

  // Control register and state
  logic [31:0]     ctrl;
  bfp_state_t      state;
  bfp_state_t      next_state;
  logic [15:0]     settle_cnt;
  logic [MV_W-1:0] oc_thresh;
  logic [2:0]      oc_cnt;
  logic            oc_fault;
  logic            ov_fault;
  logic            uv_fault;
  logic            ov_lg;
  logic            pg_ok;
  logic            ss_done;

  wire disabled   = comp_low_s | ctrl[CTRL_DISABLE_BIT];
  wire drop_start = ~supply_s | disabled;
  wire active     = (state == BFP_SOFT) | (state == BFP_RUN);
  wire settle_hit = (settle_cnt == 16'(OCSET_SETTLE_CYC - 1));
  wire any_fault  = oc_fault | ov_fault | uv_fault;
  wire stop_both  = oc_fault | uv_fault;

  always_comb begin
    next_state = state;
    case (state)
      BFP_IDLE: begin
        if (supply_s && !disabled) begin
          next_state = BFP_OCSET;
        end
      end
      BFP_OCSET: begin
        if (drop_start) begin
          next_state = BFP_IDLE;
        end else if (settle_hit) begin
          next_state = BFP_SOFT;
        end
      end
      BFP_SOFT: begin
        if (drop_start) begin
          next_state = BFP_IDLE;
        end else if (ss_done) begin
          next_state = BFP_RUN;
        end
      end
      BFP_RUN: begin
        if (drop_start) begin
          next_state = BFP_IDLE;
        end
      end
      default: begin
        next_state = BFP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= BFP_IDLE;
      settle_cnt <= '0;
    end else begin
      state      <= next_state;
      settle_cnt <= (state == BFP_OCSET) ? settle_cnt + 16'h0001 : 16'h0000;
    end
  end

  // Overcurrent threshold capture
  wire             ocset_take = (state == BFP_OCSET) & settle_hit & ~drop_start;
  wire [MV_W-1:0]  ocset_sat  = (ocset_mv > OC_THRESH_MAX_MV) ? OC_THRESH_MAX_MV : ocset_mv;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oc_thresh <= OC_THRESH_MAX_MV;
    end else if (ocset_take) begin
      oc_thresh <= ocset_sat;
    end
  end

  // Soft start ramp, precharged start capped at the reference
  wire [MV_W-1:0] pre_mv = (out_mv > VREF_MV) ? VREF_MV : out_mv;

  bfp_ramp #(.STEP_CYC(SS_STEP_CYC)) u_ramp (
    .clk     (clk),
    .reset   (reset),
    .clear   (~active & ~ocset_take),
    .start   (ocset_take),
    .init_mv (pre_mv),
    .ref_mv  (ss_reference),
    .done    (ss_done)
  );

  // Overcurrent counting once per switching cycle
  wire oc_sample = low_off_strobe & active;
  wire oc_over   = sw_drop > oc_thresh;
  wire oc_trip   = oc_sample & oc_over & (oc_cnt == OC_TRIP_COUNT - 3'h1);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oc_cnt <= '0;
    end else if (oc_sample) begin
      if (!oc_over) begin
        oc_cnt <= '0;
      end else if (oc_cnt != OC_TRIP_COUNT) begin
        oc_cnt <= oc_cnt + 3'h1;
      end
    end
  end

  // Fault latches; only reset, which is the power cycle, clears them
  wire ov_trip = active & (out_mv > OV_TRIP_MV);
  wire uv_trip = (state == BFP_RUN) & (out_mv < UV_TRIP_MV);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oc_fault <= 1'b0;
      ov_fault <= 1'b0;
      uv_fault <= 1'b0;
    end else begin
      oc_fault <= oc_fault | oc_trip;
      ov_fault <= ov_fault | ov_trip;
      uv_fault <= uv_fault | uv_trip;
    end
  end

  // Low gate hysteresis during overvoltage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ov_lg <= 1'b0;
    end else if (out_mv > OV_TRIP_MV) begin
      ov_lg <= 1'b1;
    end else if (out_mv < OV_LG_OFF_MV) begin
      ov_lg <= 1'b0;
    end
  end

  // Gate drive; the latched stop faults outrank the overvoltage clamp
  wire next_hg = active & ~any_fault & pwm_high_req;
  wire next_lg = stop_both ? 1'b0 :
                 ov_fault  ? ov_lg :
                 (active & pwm_low_req);

  // Power good window
  wire in_window = (out_mv >= PG_LOW_MV) & (out_mv <= PG_HIGH_MV);
  wire next_pg   = (state == BFP_RUN) & ~any_fault & ~ov_trip & ~uv_trip & in_window;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      high_gate_drive <= 1'b0;
      low_gate_drive  <= 1'b0;
      ocset_source_en <= 1'b0;
      pg_ok           <= 1'b0;
    end else begin
      high_gate_drive <= next_hg;
      low_gate_drive  <= next_lg;
      ocset_source_en <= (next_state == BFP_OCSET);
      pg_ok           <= next_pg;
    end
  end

  // Open drain: the pin is only ever driven low
  assign power_ok_out_o  = 1'b0;
  assign power_ok_out_oe = ~pg_ok;

  // AXI4-Lite slave: one write and one read at a time
  logic              aw_got;
  logic              w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              bvalid;
  logic [1:0]        bresp;
  logic              rvalid;
  logic [31:0]       rdata;
  logic [1:0]        rresp;

  wire aw_fire  = s_axi_req.awvalid & ~aw_got & ~bvalid;
  wire w_fire   = s_axi_req.wvalid & ~w_got & ~bvalid;
  wire wr_go    = aw_got & w_got & ~bvalid;
  wire wr_ctrl  = wr_go & (aw_addr == CTRL_OFS);
  wire wr_known = (aw_addr == CTRL_OFS) | (aw_addr == STATUS_OFS) |
                  (aw_addr == OC_THRESH_OFS) | (aw_addr == SS_REF_OFS) |
                  (aw_addr == OUT_SENSE_OFS);
  wire ar_fire  = s_axi_req.arvalid & ~rvalid;

  wire [31:0] status_word = {19'h0_0000, state, 3'h0, ss_done, pg_ok,
                             uv_fault, ov_fault, oc_fault};
  wire [31:0] oc_word     = {21'h00_0000, oc_thresh};
  wire [31:0] ss_word     = {21'h00_0000, ss_reference};
  wire [31:0] out_word    = {21'h00_0000, out_mv};
  wire        rd_ctrl     = s_axi_req.araddr == CTRL_OFS;
  wire        rd_stat     = s_axi_req.araddr == STATUS_OFS;
  wire        rd_oc       = s_axi_req.araddr == OC_THRESH_OFS;
  wire        rd_ss       = s_axi_req.araddr == SS_REF_OFS;
  wire        rd_out      = s_axi_req.araddr == OUT_SENSE_OFS;
  wire        rd_known    = rd_ctrl | rd_stat | rd_oc | rd_ss | rd_out;
  wire [31:0] rd_mux      = rd_ctrl ? ctrl : rd_stat ? status_word : rd_oc ? oc_word :
                            rd_ss ? ss_word : rd_out ? out_word : 32'h0000_0000;

  logic [31:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        next_ctrl[b*8 +: 8] = w_data[b*8 +: 8];
      end
    end
    next_ctrl[31:1] = 31'h0000_0000;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      ctrl    <= CTRL_RESET;
    end else begin
      if (aw_fire) begin
        aw_got  <= 1'b1;
        aw_addr <= s_axi_req.awaddr;
      end
      if (w_fire) begin
        w_got  <= 1'b1;
        w_data <= s_axi_req.wdata;
        w_strb <= s_axi_req.wstrb;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && s_axi_req.bready) begin
        bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= next_ctrl;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && s_axi_req.rready) begin
      rvalid <= 1'b0;
    end
  end

  assign s_axi_rsp.awready = ~aw_got & ~bvalid;
  assign s_axi_rsp.wready  = ~w_got & ~bvalid;
  assign s_axi_rsp.bvalid  = bvalid;
  assign s_axi_rsp.bresp   = bresp;
  assign s_axi_rsp.arready = ~rvalid;
  assign s_axi_rsp.rvalid  = rvalid;
  assign s_axi_rsp.rdata   = rdata;
  assign s_axi_rsp.rresp   = rresp;

endmodule

// [bfp_top_test.sv]
// Self-checking bench for the buck fault protection logic
`timescale 1ns/10ps
module bfp_top_test;
  import bfp_pkg::*;
  logic            clk, reset, supply_ok, comp_low, pwm_high_req, pwm_low_req;
  logic [MV_W-1:0] out_mv, rset_mv, drop_mv, sw_mv, ocp_mv, ssr;
  logic            strobe, hg, lg, ocs, pgo, pgoe;
  bfp_axi_req_t    req;
  bfp_axi_rsp_t    rsp;
  logic [31:0]     rd;
  logic [1:0]      rr;
  int              fails, checks_done;

  bfp_top #(.SS_TIME_US_P(16)) i_dut (.clk, .reset, .supply_ok, .comp_low,
    .low_off_strobe(strobe), .pwm_high_req, .pwm_low_req, .switch_node_sense(sw_mv),
    .output_sense(out_mv), .overcurrent_set_resistor(ocp_mv), .s_axi_req(req),
    .s_axi_rsp(rsp), .high_gate_drive(hg), .low_gate_drive(lg), .ocset_source_en(ocs),
    .power_ok_out_o(pgo), .power_ok_out_oe(pgoe), .ss_reference(ssr));
  bfp_plant i_plant (.clk, .reset, .ocset_source_en(ocs), .rset_mv, .drop_mv,
    .low_off_strobe(strobe), .switch_node_sense(sw_mv), .overcurrent_set_resistor(ocp_mv));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tmo;
    fails++;
    test_done();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // k: 0 threshold source level, 1 ramp reaches v, 2 next sample strobe
  task automatic wait_on(input int k, input logic [MV_W-1:0] v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((k == 2 ? strobe !== 1'b1 : k == 1 ? ssr < v : ocs !== v[0]) && n < 3000);
    @(posedge clk);
    if (n >= 3000) tmo();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    int n;
    bh = 1'b0;
    n = 0;
    // Let an edge pass so the previous call's last release never shares a time step with this
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1,
             default: 0};
    while (!bh && n < 50) begin
      @(negedge clk);
      ah = req.awvalid && rsp.awready;
      wh = req.wvalid && rsp.wready;
      bh = rsp.bvalid;
      rr = rsp.bresp;
      @(posedge clk);
      if (ah) req.awvalid <= 1'b0;
      if (wh) req.wvalid <= 1'b0;
      if (bh) req.bready <= 1'b0;
      n++;
    end
    if (!bh) tmo();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ah, rh;
    int n;
    rh = 1'b0;
    n = 0;
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: 0};
    while (!rh && n < 50) begin
      @(negedge clk);
      ah = req.arvalid && rsp.arready;
      rh = rsp.rvalid;
      rd = rsp.rdata;
      rr = rsp.rresp;
      @(posedge clk);
      if (ah) req.arvalid <= 1'b0;
      if (rh) req.rready <= 1'b0;
      n++;
    end
    if (!rh) tmo();
  endtask
  task automatic do_reset;
    reset <= 1'b1;
    supply_ok <= 1'b0;
    comp_low <= 1'b0;
    pwm_high_req <= 1'b1;
    pwm_low_req <= 1'b0;
    out_mv <= 11'h000;
    drop_mv <= 11'h000;
    cyc(8);
    reset <= 1'b0;
    cyc(1);
  endtask
  task automatic t_reset;
    chk({ssr, hg, lg, ocs, pgoe, pgo}, {11'h000, 5'b00010});
    axi_rd(STATUS_OFS);
    chk(rd, 32'h0000_0100);
    axi_wr(8'h44, 32'hFFFF_FFFF);
    chk(rr, RESP_SLVERR);
    axi_rd(CTRL_OFS);
    chk(rd, CTRL_RESET);
    axi_rd(8'h40);
    chk({rd[29:0], rr}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_start(input logic [MV_W-1:0] rs, input logic [MV_W-1:0] pre);
    logic [MV_W-1:0] lo;
    lo = (pre > VREF_MV) ? VREF_MV : pre;
    rset_mv <= rs;
    out_mv <= pre;
    supply_ok <= 1'b1;
    wait_on(0, 11'h001);
    chk(pgoe, 1'b1);
    wait_on(0, 11'h000);
    cyc(2);
    chk(ssr >= lo && ssr <= lo + 11'h008, 1'b1);
    axi_rd(OC_THRESH_OFS);
    chk(rd, (rs > OC_THRESH_MAX_MV) ? OC_THRESH_MAX_MV : rs);
    wait_on(1, 11'h2BC);
    out_mv <= VREF_MV;
    wait_on(1, VREF_MV);
    cyc(8);
    axi_rd(STATUS_OFS);
    chk(rd, 32'h0000_0818);
  endtask
  task automatic t_pg;
    logic [MV_W-1:0] v[4] = '{11'h2BC, 11'h371, 11'h370, 11'h2D0};
    for (int i = 0; i < 4; i++) begin
      out_mv <= v[i];
      cyc(8);
      chk(pgoe, i < 2);
    end
    out_mv <= VREF_MV;
    cyc(8);
  endtask
  task automatic t_dis;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) comp_low <= 1'b1;
      if (i == 1) axi_wr(CTRL_OFS, 32'h0000_0001);
      if (i == 2) supply_ok <= 1'b0;
      cyc(8);
      chk({ssr, ocs}, 12'h000);
      axi_rd(STATUS_OFS);
      chk(rd[12:8], 5'h01);
      comp_low <= 1'b0;
      if (i == 1) axi_wr(CTRL_OFS, 32'h0000_0000);
      t_start(11'h064, VREF_MV);
    end
  endtask
  task automatic t_oc;
    logic [MV_W-1:0] d[3] = '{11'h0C8, 11'h064, 11'h0C8};
    pwm_high_req <= 1'b0;
    pwm_low_req <= 1'b1;
    cyc(2);
    chk({hg, lg}, 2'b01);
    pwm_high_req <= 1'b1;
    cyc(2);
    chk({hg, lg}, 2'b11);
    wait_on(2, 11'h000);
    for (int i = 0; i < 3; i++) begin
      drop_mv <= d[i];
      repeat (i == 1 ? 1 : 3) wait_on(2, 11'h000);
    end
    axi_rd(STATUS_OFS);
    chk(rd[0], 1'b0);
    wait_on(2, 11'h000);
    cyc(4);
    chk({hg, lg, pgoe}, 3'b001);
    supply_ok <= 1'b0;
    cyc(10);
    supply_ok <= 1'b1;
    cyc(1200);
    axi_rd(STATUS_OFS);
    chk({rd[0], hg, lg}, 3'b100);
  endtask
  task automatic t_ov;
    logic [MV_W-1:0] v[4] = '{11'h44C, 11'h2BC, VREF_MV, 11'h18F};
    for (int i = 0; i < 4; i++) begin
      out_mv <= v[i];
      cyc(10);
      chk({hg, lg}, {1'b0, i < 3});
      if (i == 2) axi_rd(STATUS_OFS);
      if (i == 2) chk({rd[1], pgoe}, 2'b11);
    end
  endtask
  task automatic t_uv;
    pwm_low_req <= 1'b1;
    out_mv <= 11'h226;
    cyc(10);
    chk({hg, lg}, 2'b00);
    out_mv <= VREF_MV;
    cyc(10);
    axi_rd(STATUS_OFS);
    chk({rd[2], hg, lg, pgoe}, 4'b1001);
  endtask

  initial begin
    fails = 0;
    checks_done = 0;
    req <= '0;
    rset_mv <= 11'h064;
    do_reset();
    t_reset();
    t_start(11'h064, 11'h000);
    t_pg();
    t_dis();
    t_oc();
    do_reset();
    t_reset();
    t_start(11'h7FF, 11'h1F4);
    t_ov();
    do_reset();
    t_start(11'h064, 11'h000);
    t_uv();
    test_done();
  end
endmodule
